// File: dv/ccs_osc_model.sv
`timescale 1ns/100ps
// ****************************************
// free running oscillators and pll vco
// ****************************************
module ccs_osc_model #(
  parameter int HALF_NS [ccs_pkg::NUM_OSC] = '{40, 60, 100, 120, 40}
) (
  // oscillator levels: fast rc, primary, secondary, low-power rc, vco
  output logic [ccs_pkg::NUM_OSC-1:0] osc_out
);
  for (genvar i = 0; i < ccs_pkg::NUM_OSC; i++) begin : g_osc
    logic lvl;
    // rates kept in range
    // edges sit off the sampling edge so the filter sees them cleanly
    initial begin
      lvl = 1'b0;
      #1.3;
      forever #(HALF_NS[i]) lvl = ~lvl;
    end
    assign osc_out[i] = lvl;
  end
endmodule

// File: dv/test_ccs_clk_source.sv
`timescale 1ns/100ps
module test_ccs_clk_source;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk_in;
  logic srst_in;
  logic clk_en_in;
  ccs_pkg::ccs_bus_req_type bus_req;
  ccs_pkg::ccs_cfg_type cfg;
  logic [ccs_pkg::NUM_OSC-1:0] osc;
  logic [ccs_pkg::BUS_W-1:0] rdata;
  logic fosc, instr, periph, pll_en, pll_ref, pll_fb, wdt_ref, fm_ref;
  logic [ccs_pkg::TUNE_W-1:0] tune;
  logic [1:0] pmode;
  logic [2:0] src;
  logic [15:0] d;
  int fails, n_compared;

  ccs_osc_model osc_model (.osc_out(osc));

  ccs_clk_source uut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .bus_req_in(bus_req), .rdata_out(rdata), .cfg_in(cfg), .osc_in(osc),
    .fosc_out(fosc), .instr_clk_out(instr), .periph_clk_out(periph),
    .pll_enable_out(pll_en), .pll_ref_out(pll_ref), .pll_fb_out(pll_fb),
    .fast_tune_out(tune), .prim_mode_out(pmode), .cur_source_out(src),
    .wdt_ref_out(wdt_ref), .fail_mon_ref_out(fm_ref)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic do_reset(input logic [2:0] s, input logic [1:0] m,
                          input int n);
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    cfg <= ccs_pkg::ccs_cfg_type'({s, m});
    repeat (n) @(posedge sys_clk_in);
    srst_in <= 1'b0;
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge sys_clk_in);
    bus_req.addr <= a;
    bus_req.wdata <= v;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk_in);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge sys_clk_in);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk_in);
    bus_req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return fosc;
      1: return instr;
      2: return pll_ref;
      3: return pll_fb;
      4: return wdt_ref;
      default: return fm_ref;
    endcase
  endfunction

  // period between the second and third rising edge seen
  task automatic per_is(input int sel, input int exp);
    logic s, prev;
    int n, edges, per;
    prev = pick(sel);
    n = 0;
    edges = 0;
    per = 0;
    for (int i = 0; i < 20000 && edges < 3; i++) begin
      @(posedge sys_clk_in);
      #1;
      s = pick(sel);
      n++;
      if (s === 1'b1 && prev === 1'b0) begin
        edges++;
        per = n;
        n = 0;
      end
      prev = s;
    end
    chk(per, exp);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    do_reset(3'h0, 2'h0, 3);
    rd(2'h0, d); chk(d, 16'h3040);
    rd(2'h1, d); chk(d, 16'h0030);
    rd(2'h2, d); chk(d, 16'h0000);
    rd(2'h3, d); chk(d, 16'h0000);
    wr(2'h3, 16'hFFFF);
    rd(2'h3, d); chk(d, 16'h0000);
    wr(2'h0, 16'hFFFF);
    rd(2'h0, d); chk(d, 16'hFFDF);
    wr(2'h1, 16'hFFFF);
    rd(2'h1, d); chk(d, 16'h01FF);
    wr(2'h2, 16'h0015);
    #1;
    chk(tune, 6'h15);
    rd(2'h2, d); chk(d, 16'h0015);
    $display("test regs done");
  endtask

  task automatic t_sources;
    logic [2:0] srcs [6];
    int pers [6];
    srcs = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    pers = '{16, 24, 40, 48, 256, 32};
    for (int i = 0; i < 6; i++) begin
      do_reset(srcs[i], 2'h1, 3);
      @(posedge sys_clk_in);
      chk(src, srcs[i]);
      chk(pll_en, 1'b0);
      per_is(0, pers[i]);
      per_is(1, 2 * pers[i]);
      chk(periph, instr);
    end
    for (int s = 2; s < 4; s++) begin
      for (int m = 0; m < 3; m++) begin
        do_reset(s[2:0], m[1:0], 3);
        rd(2'h3, d);
        chk(d, {10'h0, s[0], m[1:0], s[2:0]});
        chk(pmode, m[1:0]);
      end
    end
    $display("test sources done");
  endtask

  task automatic t_frc_divide_select;
    do_reset(3'h7, 2'h0, 3);
    per_is(0, 32);
    wr(2'h0, 16'h3740);
    per_is(0, 4096);
    wr(2'h0, 16'h3340);
    per_is(0, 256);
    $display("test frc divide done");
  endtask

  task automatic t_pll;
    int hi;
    do_reset(3'h3, 2'h2, 3);
    @(posedge sys_clk_in);
    chk(pll_en, 1'b1);
    per_is(2, 48);
    per_is(3, 800);
    per_is(0, 64);
    wr(2'h1, 16'h001E);
    per_is(3, 512);
    wr(2'h0, 16'h3000);
    per_is(0, 32);
    wr(2'h0, 16'h30C0);
    per_is(0, 128);
    per_is(1, 256);
    wr(2'h0, 16'h301F);
    per_is(2, 792);
    do_reset(3'h1, 2'h0, 3);
    per_is(2, 32);
    per_is(0, 64);
    do_reset(3'h2, 2'h0, 3);
    hi = 0;
    repeat (100) begin
      @(posedge sys_clk_in);
      #1;
      if (pll_ref !== 1'b0) hi++;
    end
    chk(hi, 0);
    $display("test pll done");
  endtask

  task automatic t_refs_cfg;
    int tg;
    logic f;
    do_reset(3'h7, 2'h3, 3);
    per_is(4, 48);
    per_is(5, 48);
    chk(src, 3'h7);
    @(posedge sys_clk_in);
    cfg <= ccs_pkg::ccs_cfg_type'(5'h00);
    repeat (20) @(posedge sys_clk_in);
    chk(src, 3'h7);
    chk(pmode, 2'h3);
    rd(2'h3, d); chk(d, 16'h001F);
    @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    wr(2'h2, 16'h003F);
    #1;
    f = fosc;
    tg = 0;
    repeat (60) begin
      @(posedge sys_clk_in);
      #1;
      if (fosc !== f) tg++;
    end
    chk(tg, 0);
    chk(tune, 6'h00);
    @(posedge sys_clk_in);
    clk_en_in <= 1'b1;
    per_is(0, 32);
    $display("test refs and config done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(90000 * 5);
    fails++;
    end_of_test();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    srst_in = 1'b1;
    clk_en_in = 1'b1;
    bus_req = '0;
    cfg = '0;
    do_reset(3'h0, 2'h0, 12);
    t_regs();
    t_sources();
    t_frc_divide_select();
    t_pll();
    t_refs_cfg();
    end_of_test();
  end
endmodule

// File: logic/ccs_clk_div.sv
`timescale 1ns/100ps
module ccs_clk_div #(
  parameter int W = ccs_pkg::DIV_W
) (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // source edge and factor
  input wire logic tick_in,
  input wire logic [W-1:0] factor_in,
  // divided clock
  output logic clk_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [W-1:0] fac;
    logic [W:0] cnt;
    logic out;
  } ccs_div_state_type;

  localparam logic [W-1:0] FAC_MIN = W'(1);
  localparam logic [W:0] CNT_ONE = (W+1)'(1);
  localparam ccs_div_state_type DIV_RST = '{fac: FAC_MIN, cnt: '0, out: 1'b0};

  ccs_div_state_type st_q;
  ccs_div_state_type st_d;
  logic [W:0] top;
  logic [W:0] half;

  // ****************************************
  // counter over both source edges
  // ****************************************
  always_comb begin
    st_d = st_q;
    top = {st_q.fac, 1'b0} - CNT_ONE;
    half = {1'b0, st_q.fac} - CNT_ONE;
    if (srst_in) begin
      st_d = DIV_RST;
    end else if (tick_in) begin
      // factor taken only at period end
      if (st_q.cnt == top) begin
        st_d.cnt = '0;
        st_d.out = 1'b1;
        st_d.fac = (factor_in == '0) ? FAC_MIN : factor_in;
      end else begin
        if (st_q.cnt == half) begin
          st_d.out = 1'b0;
        end
        st_d.cnt = st_q.cnt + CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || clk_en_in) begin
      st_q <= st_d;
    end
  end

  assign clk_out = st_q.out;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_tick_at_top;
    tick_in && clk_en_in && (st_q.cnt == top);
  endsequence

  a_div_latch_edge: assert property (
    $changed(st_q.fac) |-> (st_q.cnt == '0) && st_q.out
  ) else $error("divide factor changed inside a period");

  a_div_rise_top: assert property (
    $rose(st_q.out) |-> $past(tick_in && clk_en_in && (st_q.cnt == top))
  ) else $error("divided clock rose away from period end");

  a_div_top_rise: assert property (
    s_tick_at_top |=> st_q.out && (st_q.cnt == '0)
  ) else $error("period end did not restart high");

endmodule

// File: logic/ccs_clk_source.sv
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
// Operation
// - eight clock choices: fast RC, primary, both via PLL, secondary, slow RC, fast RC divided by 16 and by N.
// - fast RC divided by 2 to 256, chosen by a three-bit field.
// - tuning register value drives the fast RC trim output.
// - power-on source from three-bit source field plus two-bit primary mode.
// - erased configuration selects a fast RC based source.
// - twelve clock modes from source field and primary mode combinations.
// - instruction and peripheral clocks are the system clock divided by two.
// - only primary and fast RC may feed the PLL.
// - PLL input divided by prescale 2 to 33 from low five bits.
// - feedback factor comes from nine-bit field of feedback register.
// - postscale 2, 4 or 8 from bits seven to six.
// - PLL output is input times feedback over prescale times postscale.
// - low-power RC feeds watchdog timer and clock fail monitor references.
// - source codes 000 to 111 decode to the eight source paths.
// - prescale zero gives 2, feedback 1E gives 32, postscale zero gives 2.
module ccs_clk_source (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // register port
  input wire ccs_pkg::ccs_bus_req_type bus_req_in,
  output logic [ccs_pkg::BUS_W-1:0] rdata_out,
  // nonvolatile configuration
  input wire ccs_pkg::ccs_cfg_type cfg_in,
  // oscillator and pll core clocks
  input wire logic [ccs_pkg::NUM_OSC-1:0] osc_in,
  // generated clocks
  output logic fosc_out,
  output logic instr_clk_out,
  output logic periph_clk_out,
  // pll core control
  output logic pll_enable_out,
  output logic pll_ref_out,
  output logic pll_fb_out,
  // oscillator control and references
  output logic [ccs_pkg::TUNE_W-1:0] fast_tune_out,
  output logic [1:0] prim_mode_out,
  output logic [2:0] cur_source_out,
  output logic wdt_ref_out,
  output logic fail_mon_ref_out
);

  localparam int DW = ccs_pkg::DIV_W;
  localparam int BW = ccs_pkg::BUS_W;

  ccs_pkg::ccs_state_type st_q;
  ccs_pkg::ccs_state_type st_d;
  logic fosc_sel;
  logic post_clk;
  logic frcn_clk;
  logic frc16_clk;
  logic pll_in_tick;
  logic vco_tick;
  logic [DW-1:0] frcn_factor;
  logic [DW-1:0] pre_factor;
  logic [DW-1:0] fb_factor;
  logic [DW-1:0] post_factor;

  // ****************************************
  // checks shared setup
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  // ****************************************
  // divide factors from the registers
  // ****************************************
  // power of two from 2 to 256
  assign frcn_factor = ccs_pkg::FRCN_BASE <<
    st_q.clock_divisor_reg[ccs_pkg::FAST_DIV_LSB +: ccs_pkg::FAST_DIV_W];
  assign pre_factor = DW'(st_q.clock_divisor_reg[ccs_pkg::PRE_LSB +:
    ccs_pkg::PRE_W]) + ccs_pkg::PRE_BASE;
  assign fb_factor = DW'(st_q.pll_feedback_reg) + ccs_pkg::FB_BASE;

  // postscale decode, reserved code taken as four
  always_comb begin
    case (st_q.clock_divisor_reg[ccs_pkg::POST_LSB +: ccs_pkg::POST_W])
      ccs_pkg::POST_SEL_2: post_factor = ccs_pkg::POST2;
      ccs_pkg::POST_SEL_8: post_factor = ccs_pkg::POST8;
      default: post_factor = ccs_pkg::POST4;
    endcase
  end

  // pll input gated to fast RC or primary
  assign pll_in_tick = st_q.pll_en &&
    ((st_q.cfg.initial_source_select == ccs_pkg::SRC_FAST_PLL) ?
     st_q.edge_seen[ccs_pkg::OSC_FAST] : st_q.edge_seen[ccs_pkg::OSC_PRI]);
  assign vco_tick = st_q.pll_en && st_q.edge_seen[ccs_pkg::OSC_VCO];

  // ****************************************
  // source selection
  // ****************************************
  // eight clock choices, source decode
  always_comb begin
    case (st_q.cfg.initial_source_select)
      ccs_pkg::SRC_FAST: fosc_sel = st_q.lvl[ccs_pkg::OSC_FAST];
      ccs_pkg::SRC_FAST_PLL: fosc_sel = post_clk;
      ccs_pkg::SRC_PRI: fosc_sel = st_q.lvl[ccs_pkg::OSC_PRI];
      ccs_pkg::SRC_PRI_PLL: fosc_sel = post_clk;
      ccs_pkg::SRC_SEC: fosc_sel = st_q.lvl[ccs_pkg::OSC_SEC];
      ccs_pkg::SRC_SLOW_RC: fosc_sel = st_q.lvl[ccs_pkg::OSC_SLOW];
      ccs_pkg::SRC_FAST_DIV16: fosc_sel = frc16_clk;
      default: fosc_sel = frcn_clk;
    endcase
  end

  // ****************************************
  // state update
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    for (int i = 0; i < ccs_pkg::NUM_OSC; i++) begin
      st_d.sync[i][0] = osc_in[i];
      st_d.sync[i][1] = st_q.sync[i][0];
      st_d.sync[i][2] = st_q.sync[i][1];
      if (st_q.sync[i][1] == st_q.sync[i][2]) begin
        st_d.lvl[i] = st_q.sync[i][2];
      end
      st_d.edge_seen[i] = (st_d.lvl[i] != st_q.lvl[i]);
    end
    st_d.lref = st_q.lvl[ccs_pkg::OSC_SLOW];
    st_d.fosc = fosc_sel;
    st_d.fosc_edge = (fosc_sel != st_q.fosc);
    if (bus_req_in.wr) begin
      if (bus_req_in.addr == ccs_pkg::ADDR_DIV) begin
        st_d.clock_divisor_reg = bus_req_in.wdata & ccs_pkg::DIV_WMASK;
      end else if (bus_req_in.addr == ccs_pkg::ADDR_FBD) begin
        st_d.pll_feedback_reg = bus_req_in.wdata[ccs_pkg::FBD_W-1:0];
      end else if (bus_req_in.addr == ccs_pkg::ADDR_TUNE) begin
        st_d.tune = bus_req_in.wdata[ccs_pkg::TUNE_W-1:0];
      end
    end
    if (bus_req_in.rd) begin
      if (bus_req_in.addr == ccs_pkg::ADDR_DIV) begin
        st_d.rdata = st_q.clock_divisor_reg;
      end else if (bus_req_in.addr == ccs_pkg::ADDR_FBD) begin
        st_d.rdata = BW'(st_q.pll_feedback_reg);
      end else if (bus_req_in.addr == ccs_pkg::ADDR_TUNE) begin
        st_d.rdata = BW'(st_q.tune);
      end else begin
        st_d.rdata[ccs_pkg::STAT_SRC_LSB +: 3] =
          st_q.cfg.initial_source_select;
        st_d.rdata[ccs_pkg::STAT_PMODE_LSB +: 2] = st_q.cfg.primary_osc_mode;
        st_d.rdata[ccs_pkg::STAT_PLL_BIT] = st_q.pll_en;
      end
    end
    if (srst_in) begin
      st_d = '0;
      // capture source and primary mode, only here
      // erased or any of twelve modes
      st_d.cfg = cfg_in;
      st_d.pll_en =
        (cfg_in.initial_source_select == ccs_pkg::SRC_FAST_PLL) ||
        (cfg_in.initial_source_select == ccs_pkg::SRC_PRI_PLL);
      st_d.clock_divisor_reg = ccs_pkg::DIV_RESET;
      st_d.pll_feedback_reg = ccs_pkg::FBD_RESET;
      st_d.tune = ccs_pkg::TUNE_RESET;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || clk_en_in) begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // dividers
  // ****************************************
  // fast RC divided by N
  ccs_clk_div #(.W(DW)) u_frcn (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tick_in(st_q.edge_seen[ccs_pkg::OSC_FAST]),
    .factor_in(frcn_factor),
    .clk_out(frcn_clk)
  );

  ccs_clk_div #(.W(DW)) u_frc16 (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tick_in(st_q.edge_seen[ccs_pkg::OSC_FAST]),
    .factor_in(ccs_pkg::FRC16_FACTOR),
    .clk_out(frc16_clk)
  );

  // prescaled reference for the pll core
  ccs_clk_div #(.W(DW)) u_pre (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tick_in(pll_in_tick),
    .factor_in(pre_factor),
    .clk_out(pll_ref_out)
  );

  // feedback divider closes the loop, output ratio
  ccs_clk_div #(.W(DW)) u_fb (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tick_in(vco_tick),
    .factor_in(fb_factor),
    .clk_out(pll_fb_out)
  );

  ccs_clk_div #(.W(DW)) u_post (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tick_in(vco_tick),
    .factor_in(post_factor),
    .clk_out(post_clk)
  );

  ccs_clk_div #(.W(DW)) u_instr (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tick_in(st_q.fosc_edge),
    .factor_in(ccs_pkg::INSTR_FACTOR),
    .clk_out(instr_clk_out)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign periph_clk_out = instr_clk_out;
  assign fosc_out = st_q.fosc;
  assign rdata_out = st_q.rdata;
  assign pll_enable_out = st_q.pll_en;
  assign fast_tune_out = st_q.tune;
  assign prim_mode_out = st_q.cfg.primary_osc_mode;
  assign cur_source_out = st_q.cfg.initial_source_select;
  assign wdt_ref_out = st_q.lref;
  assign fail_mon_ref_out = st_q.lref;

  // ****************************************
  // checks
  // ****************************************
  sequence s_div_write;
    clk_en_in && bus_req_in.wr && (bus_req_in.addr == ccs_pkg::ADDR_DIV);
  endsequence

  sequence s_fbd_write;
    clk_en_in && bus_req_in.wr && (bus_req_in.addr == ccs_pkg::ADDR_FBD);
  endsequence

  a_cfg_capture: assert property (
    $fell(srst_in) |-> (st_q.cfg == $past(cfg_in))
  ) else $error("configuration not captured at reset");

  a_cfg_erased: assert property (
    $fell(srst_in) && ($past(cfg_in) == '1) |->
      (st_q.cfg.initial_source_select == ccs_pkg::SRC_FAST_DIVN)
  ) else $error("erased configuration did not pick fast RC");

  a_cfg_hold: assert property (
    !$past(srst_in) |-> $stable(st_q.cfg) && $stable(st_q.pll_en)
  ) else $error("configuration changed outside reset");

  a_tune_write: assert property (
    clk_en_in && bus_req_in.wr && (bus_req_in.addr == ccs_pkg::ADDR_TUNE)
      |=> fast_tune_out == $past(bus_req_in.wdata[ccs_pkg::TUNE_W-1:0])
  ) else $error("tuning output did not follow write");

  a_frcn_max: assert property (
    s_div_write ##0 (bus_req_in.wdata[ccs_pkg::FAST_DIV_LSB +:
      ccs_pkg::FAST_DIV_W] == '1) |=> frcn_factor == ccs_pkg::FRCN_MAX
  ) else $error("largest fast RC divide is not 256");

  a_pre_zero: assert property (
    s_div_write ##0 (bus_req_in.wdata[ccs_pkg::PRE_LSB +:
      ccs_pkg::PRE_W] == '0) |=> pre_factor == ccs_pkg::PRE_BASE
  ) else $error("prescale zero is not two");

  a_post_eight: assert property (
    s_div_write ##0 (bus_req_in.wdata[ccs_pkg::POST_LSB +:
      ccs_pkg::POST_W] == ccs_pkg::POST_SEL_8)
      |=> post_factor == ccs_pkg::POST8
  ) else $error("postscale code three is not eight");

  a_fb_example: assert property (
    s_fbd_write ##0 (bus_req_in.wdata[ccs_pkg::FBD_W-1:0] ==
      ccs_pkg::FB_EX_SEL) |=> fb_factor == ccs_pkg::FB_EX_FACTOR
  ) else $error("feedback 1E is not 32");

  a_pll_input_only: assert property (
    $changed(pll_ref_out) || $changed(post_clk) |-> st_q.pll_en
  ) else $error("pll path moved in a non pll mode");

  a_decode_primary: assert property (
    clk_en_in && (st_q.cfg.initial_source_select == ccs_pkg::SRC_PRI)
      |=> st_q.fosc == $past(st_q.lvl[ccs_pkg::OSC_PRI])
  ) else $error("primary mode not routed to system clock");

  a_decode_pll: assert property (
    clk_en_in && st_q.pll_en |=> st_q.fosc == $past(post_clk)
  ) else $error("pll mode not routed to system clock");

  a_instr_follow: assert property (
    $changed(instr_clk_out) |-> $past(st_q.fosc_edge && clk_en_in)
  ) else $error("instruction clock moved without a system clock edge");

  a_slow_ref: assert property (
    clk_en_in |=> wdt_ref_out == $past(st_q.lvl[ccs_pkg::OSC_SLOW])
  ) else $error("reference does not follow low-power RC");

endmodule

// File: logic/ccs_pkg.sv
package ccs_pkg;

  // ****************************************
  // widths and oscillator pin indices
  // ****************************************
  localparam int DIV_W = 10;
  localparam int BUS_W = 16;
  localparam int ADDR_W = 2;
  localparam int TUNE_W = 6;
  localparam int FBD_W = 9;
  localparam int NUM_OSC = 5;
  localparam int SYNC_LEN = 3;
  localparam int OSC_FAST = 0;
  localparam int OSC_PRI = 1;
  localparam int OSC_SEC = 2;
  localparam int OSC_SLOW = 3;
  localparam int OSC_VCO = 4;

  // ****************************************
  // register offsets, fields and reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_DIV = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_FBD = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_TUNE = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h3;
  localparam logic [BUS_W-1:0] DIV_RESET = 16'h3040;
  localparam logic [BUS_W-1:0] DIV_WMASK = 16'hFFDF;
  localparam logic [FBD_W-1:0] FBD_RESET = 9'h030;
  localparam logic [TUNE_W-1:0] TUNE_RESET = 6'h00;
  localparam int PRE_LSB = 0;
  localparam int PRE_W = 5;
  localparam int POST_LSB = 6;
  localparam int POST_W = 2;
  localparam int FAST_DIV_LSB = 8;
  localparam int FAST_DIV_W = 3;
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_PMODE_LSB = 3;
  localparam int STAT_PLL_BIT = 5;

  // ****************************************
  // divide factors
  // ****************************************
  localparam logic [DIV_W-1:0] PRE_BASE = 10'h002;
  localparam logic [DIV_W-1:0] FB_BASE = 10'h002;
  localparam logic [DIV_W-1:0] FRCN_BASE = 10'h002;
  localparam logic [DIV_W-1:0] FRCN_MAX = 10'h100;
  localparam logic [DIV_W-1:0] FRC16_FACTOR = 10'h010;
  localparam logic [DIV_W-1:0] INSTR_FACTOR = 10'h002;
  localparam logic [DIV_W-1:0] POST2 = 10'h002;
  localparam logic [DIV_W-1:0] POST4 = 10'h004;
  localparam logic [DIV_W-1:0] POST8 = 10'h008;
  localparam logic [DIV_W-1:0] FB_EX_FACTOR = 10'h020;
  localparam logic [FBD_W-1:0] FB_EX_SEL = 9'h01E;
  localparam logic [POST_W-1:0] POST_SEL_2 = 2'h0;
  localparam logic [POST_W-1:0] POST_SEL_4 = 2'h1;
  localparam logic [POST_W-1:0] POST_SEL_8 = 2'h3;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SRC_FAST = 3'h0,
    SRC_FAST_PLL = 3'h1,
    SRC_PRI = 3'h2,
    SRC_PRI_PLL = 3'h3,
    SRC_SEC = 3'h4,
    SRC_SLOW_RC = 3'h5,
    SRC_FAST_DIV16 = 3'h6,
    SRC_FAST_DIVN = 3'h7
  } ccs_source_type;

  typedef enum logic [1:0] {
    PMODE_EXTERNAL_CLOCK = 2'h0,
    PMODE_CRYSTAL = 2'h1,
    PMODE_HIGH_SPEED_CRYSTAL = 2'h2,
    PMODE_OFF = 2'h3
  } ccs_pmode_type;

  typedef struct packed {
    ccs_source_type initial_source_select;
    ccs_pmode_type primary_osc_mode;
  } ccs_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BUS_W-1:0] wdata;
    logic wr;
    logic rd;
  } ccs_bus_req_type;

  typedef struct packed {
    ccs_cfg_type cfg;
    logic pll_en;
    logic [BUS_W-1:0] clock_divisor_reg;
    logic [FBD_W-1:0] pll_feedback_reg;
    logic [TUNE_W-1:0] tune;
    logic [NUM_OSC-1:0][SYNC_LEN-1:0] sync;
    logic [NUM_OSC-1:0] lvl;
    logic [NUM_OSC-1:0] edge_seen;
    logic fosc;
    logic fosc_edge;
    logic lref;
    logic [BUS_W-1:0] rdata;
  } ccs_state_type;

endpackage
